//--- scan_port_pkg.sv
// Purpose: shared constants and types of the boundary-scan test port
// Assumes: one test clock domain (tck) and one core domain (clk)
// Notes: instruction codes and identification value are local choices
// Function
// - power-up resets test state machine automatically
// - no dedicated test reset input pin
// - five instructions with standard register selection
// - every input and io pin has cell
// - cells: up to three capture, two update
// - separate cell variants for pins and macrocells
// - cells chained serially from tdi to tdo
// - capture samples, shift shifts, update transfers
// - cell strobes generated by test state machine
// - port optional; disabled pins become user io
// - selectable pull-ups on tms and tdi
package scan_port_pkg;

    localparam int IR_LEN = 4;
    localparam int ID_LEN = 32;
    localparam int NUM_IO = 68;
    localparam int NUM_IN = 4;
    localparam int NUM_MC = 64;
    localparam int IO_CAP = 3;
    localparam int IO_UPD = 2;
    localparam int IN_CAP = 1;
    localparam int MC_CAP = 1;

    localparam logic [IR_LEN-1:0] INS_EXTEST = 4'h0;
    localparam logic [IR_LEN-1:0] INS_SAMPLE = 4'h1;
    localparam logic [IR_LEN-1:0] INS_IDCODE = 4'h2;
    localparam logic [IR_LEN-1:0] INS_HIGHZ = 4'h3;
    localparam logic [IR_LEN-1:0] INS_BYPASS = 4'hF;
    localparam logic [1:0] IR_CAPTURE = 2'h1;

    // arbitrary identification value, bit 0 set as the scan standard asks
    localparam logic [ID_LEN-1:0] ID_VALUE = 32'h0A5C_3001;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
        ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_e;

endpackage

//--- scan_cell.sv
// Purpose: one boundary-scan cell with capture/shift and update stages
// Assumes: strobes come from the test state machine on tck
// Notes: NUPD of zero gives a capture-only cell
module scan_cell #(
    parameter int NCAP = 3,
    parameter int NUPD = 2
) (
    input wire logic tck,
    input wire logic rst_t,
    input wire logic cap_dr,
    input wire logic shift_dr,
    input wire logic upd_dr,
    input wire logic scan_in,
    input wire logic [NCAP-1:0] par_in,
    output logic scan_out,
    output logic [(NUPD>0 ? NUPD : 1)-1:0] upd_out
);
    logic [NCAP-1:0] cap_q;
    logic [NCAP-1:0] cap_d;
    logic [NCAP:0] shifted;

    // ------------------------------------------------------------
    // capture and shift stages
    // ------------------------------------------------------------
    always_comb
    begin
        shifted = {cap_q, scan_in};
        cap_d = cap_q;
        if (cap_dr)
            cap_d = par_in;
        else if (shift_dr)
            cap_d = shifted[NCAP-1:0];
    end

    always_ff @(posedge tck)
    begin
        if (rst_t)
            cap_q <= '0;
        else
            cap_q <= cap_d;
    end

    assign scan_out = cap_q[NCAP-1];

    // ------------------------------------------------------------
    // update stages
    // ------------------------------------------------------------
    generate
        if (NUPD > 0)
        begin : g_upd
            logic [NUPD-1:0] upd_q;
            logic [NUPD-1:0] upd_d;
            always_comb
            begin
                upd_d = upd_q;
                if (upd_dr)
                    upd_d = cap_q[NCAP-1 -: NUPD];
            end
            always_ff @(posedge tck)
            begin
                if (rst_t)
                    upd_q <= '0;
                else
                    upd_q <= upd_d;
            end
            assign upd_out = upd_q;
        end
        else
        begin : g_noupd
            assign upd_out = '0;
        end
    endgenerate

endmodule // scan_cell

//--- scan_test_port.sv
// Purpose: test access port, instruction decode and boundary chain
// Assumes: sys_rst is the power-on reset; tck is the link clock
// Notes: tdo changes on the falling tck edge
module scan_test_port #(
    parameter logic PULLUP_EN = 1'b1,
    parameter int N_IO = scan_port_pkg::NUM_IO,
    parameter int N_IN = scan_port_pkg::NUM_IN,
    parameter int N_MC = scan_port_pkg::NUM_MC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scan_port_en,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_out,
    output logic tdo_oe,
    output logic tms_pullup_en,
    output logic tdi_pullup_en,
    output logic test_pins_user,
    input wire logic [N_IO-1:0] io_pin_in,
    input wire logic [N_IN-1:0] in_pin_in,
    input wire logic [N_IO-1:0] core_out,
    input wire logic [N_IO-1:0] core_oe,
    input wire logic [N_MC-1:0] mc_state,
    output logic [N_IO-1:0] io_pin_out,
    output logic [N_IO-1:0] io_pin_oe
);
    import scan_port_pkg::*;

    localparam int N_CELL = N_IO + N_IN + N_MC;

    // ------------------------------------------------------------
    // reset into the test clock domain
    // ------------------------------------------------------------
    // no test reset pin exists; power-on reset, a disabled port and tms ones are the only ways
    logic por_m_q, por_q, en_m_q, en_q, rst_t;

    always_ff @(posedge tck)
    begin
        por_m_q <= sys_rst;
        por_q <= por_m_q;
        en_m_q <= scan_port_en;
        en_q <= en_m_q;
    end

    // a disabled port is held in reset so its pins stay free for user logic
    assign rst_t = por_q | ~en_q;

    // ------------------------------------------------------------
    // live signals into the test domain
    // ------------------------------------------------------------
    logic [N_IO-1:0] io_m_q, io_s_q, out_m_q, out_s_q, oe_m_q, oe_s_q;
    logic [N_IN-1:0] in_m_q, in_s_q;
    logic [N_MC-1:0] mc_m_q, mc_s_q;

    // bits are sampled independently; only the capture edge matters
    always_ff @(posedge tck)
    begin
        io_m_q <= io_pin_in;
        io_s_q <= io_m_q;
        out_m_q <= core_out;
        out_s_q <= out_m_q;
        oe_m_q <= core_oe;
        oe_s_q <= oe_m_q;
        in_m_q <= in_pin_in;
        in_s_q <= in_m_q;
        mc_m_q <= mc_state;
        mc_s_q <= mc_m_q;
    end

    // ------------------------------------------------------------
    // test state machine and instruction register
    // ------------------------------------------------------------
    tap_state_e state_q, state_d;
    logic [IR_LEN-1:0] ir_q, ir_d, ir_sh_q, ir_sh_d;
    logic byp_q, byp_d;
    logic [ID_LEN-1:0] id_q, id_d;
    logic sel_bsr, sel_id, is_ext, is_hz;
    logic cap_dr, shift_dr, upd_dr;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
        endcase
        ir_sh_d = ir_sh_q;
        ir_d = ir_q;
        if (state_q == ST_CAP_IR)
            ir_sh_d = {{(IR_LEN-2){1'b0}}, IR_CAPTURE};
        else if (state_q == ST_SHIFT_IR)
            ir_sh_d = {tdi, ir_sh_q[IR_LEN-1:1]};
        if (state_q == ST_RESET)
            ir_d = INS_IDCODE;
        else if (state_q == ST_UPD_IR)
            ir_d = ir_sh_q;
        byp_d = byp_q;
        id_d = id_q;
        if (state_q == ST_CAP_DR)
        begin
            byp_d = 1'b0;
            id_d = ID_VALUE;
        end
        else if (state_q == ST_SHIFT_DR)
        begin
            byp_d = tdi;
            id_d = {tdi, id_q[ID_LEN-1:1]};
        end
    end

    always_ff @(posedge tck)
    begin
        if (rst_t)
        begin
            state_q <= ST_RESET;
            ir_q <= INS_IDCODE;
            ir_sh_q <= '0;
            byp_q <= 1'b0;
            id_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            ir_q <= ir_d;
            ir_sh_q <= ir_sh_d;
            byp_q <= byp_d;
            id_q <= id_d;
        end
    end

    // unknown codes fall back to the one-bit path
    assign sel_bsr = (ir_q == INS_SAMPLE) || (ir_q == INS_EXTEST);
    assign sel_id = (ir_q == INS_IDCODE);
    assign is_ext = (ir_q == INS_EXTEST);
    assign is_hz = (ir_q == INS_HIGHZ);
    assign cap_dr = sel_bsr && (state_q == ST_CAP_DR);
    assign shift_dr = sel_bsr && (state_q == ST_SHIFT_DR);
    assign upd_dr = sel_bsr && (state_q == ST_UPD_DR);

    // ------------------------------------------------------------
    // boundary chain
    // ------------------------------------------------------------
    logic [N_CELL:0] chain;
    logic [N_IO-1:0] upd_out_q, upd_oe_q;

    assign chain[0] = tdi;

    genvar gi;
    generate
        for (gi = 0; gi < N_IO; gi++)
        begin : g_io
            logic [IO_UPD-1:0] upd;
            scan_cell #(.NCAP(IO_CAP), .NUPD(IO_UPD)) u_cell (
                .tck(tck),
                .rst_t(rst_t),
                .cap_dr(cap_dr),
                .shift_dr(shift_dr),
                .upd_dr(upd_dr),
                .scan_in(chain[gi]),
                .par_in({oe_s_q[gi], out_s_q[gi], io_s_q[gi]}),
                .scan_out(chain[gi+1]),
                .upd_out(upd)
            );
            assign upd_out_q[gi] = upd[0];
            assign upd_oe_q[gi] = upd[1];
        end
        for (gi = 0; gi < N_IN; gi++)
        begin : g_in
            scan_cell #(.NCAP(IN_CAP), .NUPD(0)) u_cell (
                .tck(tck),
                .rst_t(rst_t),
                .cap_dr(cap_dr),
                .shift_dr(shift_dr),
                .upd_dr(upd_dr),
                .scan_in(chain[N_IO+gi]),
                .par_in(in_s_q[gi]),
                .scan_out(chain[N_IO+gi+1]),
                .upd_out()
            );
        end
        for (gi = 0; gi < N_MC; gi++)
        begin : g_mc
            scan_cell #(.NCAP(MC_CAP), .NUPD(0)) u_cell (
                .tck(tck),
                .rst_t(rst_t),
                .cap_dr(cap_dr),
                .shift_dr(shift_dr),
                .upd_dr(upd_dr),
                .scan_in(chain[N_IO+N_IN+gi]),
                .par_in(mc_s_q[gi]),
                .scan_out(chain[N_IO+N_IN+gi+1]),
                .upd_out()
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // tdo on the falling edge
    // ------------------------------------------------------------
    logic tdo_d, tdo_q, tdo_oe_d, tdo_oe_q;

    always_comb
    begin
        if (state_q == ST_SHIFT_IR)
            tdo_d = ir_sh_q[0];
        else if (sel_bsr)
            tdo_d = chain[N_CELL];
        else if (sel_id)
            tdo_d = id_q[0];
        else
            tdo_d = byp_q;
        tdo_oe_d = (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);
    end

    always_ff @(negedge tck)
    begin
        if (rst_t)
        begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign tdo_out = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // ------------------------------------------------------------
    // pin drive in the core domain
    // ------------------------------------------------------------
    logic ext_m_q, ext_s_q, hz_m_q, hz_s_q, pe_m_q, pe_s_q;
    logic [N_IO-1:0] uo_m_q, uo_s_q, ue_m_q, ue_s_q;
    logic [N_IO-1:0] pin_out_q, pin_out_d, pin_oe_q, pin_oe_d;
    logic user_q, user_d;

    // update stages hold still while mode flags settle, so bitwise sync suffices
    always_ff @(posedge clk)
    begin
        ext_m_q <= is_ext && !rst_t;
        ext_s_q <= ext_m_q;
        hz_m_q <= is_hz && !rst_t;
        hz_s_q <= hz_m_q;
        pe_m_q <= scan_port_en;
        pe_s_q <= pe_m_q;
        uo_m_q <= upd_out_q;
        uo_s_q <= uo_m_q;
        ue_m_q <= upd_oe_q;
        ue_s_q <= ue_m_q;
    end

    always_comb
    begin
        pin_out_d = ext_s_q ? uo_s_q : core_out;
        if (hz_s_q)
            pin_oe_d = '0;
        else if (ext_s_q)
            pin_oe_d = ue_s_q;
        else
            pin_oe_d = core_oe;
        user_d = ~pe_s_q;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
            user_q <= 1'b1;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            user_q <= user_d;
        end
    end

    assign io_pin_out = pin_out_q;
    assign io_pin_oe = pin_oe_q;
    assign test_pins_user = user_q;
    assign tms_pullup_en = PULLUP_EN;
    assign tdi_pullup_en = PULLUP_EN;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_por_reset: assert property (@(posedge tck) rst_t |=> state_q == ST_RESET && ir_q == INS_IDCODE)
        else $error("state machine not reset");
    a_tms_reset: assert property (@(posedge tck) disable iff (rst_t) tms [*5] |=> state_q == ST_RESET)
        else $error("five tms ones did not reset");
    a_bypass_zero: assert property (@(posedge tck) disable iff (rst_t)
        state_q == ST_CAP_DR |=> byp_q == 1'b0)
        else $error("bypass did not capture zero");
    a_bypass_shift: assert property (@(posedge tck) disable iff (rst_t)
        state_q == ST_SHIFT_DR |=> byp_q == $past(tdi))
        else $error("bypass did not shift tdi");
    a_id_capture: assert property (@(posedge tck) disable iff (rst_t)
        state_q == ST_CAP_DR ##1 state_q == ST_SHIFT_DR |-> id_q == ID_VALUE)
        else $error("identification value not captured");
    a_ir_capture: assert property (@(posedge tck) disable iff (rst_t)
        state_q == ST_CAP_IR |=> ir_sh_q[1:0] == IR_CAPTURE)
        else $error("instruction capture pattern wrong");
    a_ir_update: assert property (@(posedge tck) disable iff (rst_t)
        state_q == ST_UPD_IR |=> ir_q == $past(ir_sh_q))
        else $error("instruction not updated");
    a_update_hold: assert property (@(posedge tck) disable iff (rst_t)
        state_q != ST_UPD_DR |=> $stable(upd_out_q) && $stable(upd_oe_q))
        else $error("update stage changed outside update");
    a_highz_pins: assert property (@(posedge clk) disable iff (sys_rst) hz_s_q |=> io_pin_oe == '0)
        else $error("pins driven under highz");
    a_extest_drive: assert property (@(posedge clk) disable iff (sys_rst)
        ext_s_q && !hz_s_q |=> io_pin_out == $past(uo_s_q) && io_pin_oe == $past(ue_s_q))
        else $error("extest pins not from update stages");

endmodule // scan_test_port

//--- scan_controller.sv
// Purpose: model of the external scan controller on the test link
// Assumes: tck idles low and runs only while a frame is sent
// Notes: tms and tdi hold their last values between frames
module scan_controller (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // ----------------------------------------
    // one test clock period, 64 ns
    // ----------------------------------------
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #32;
        // tdo has stood since the last falling edge
        o = tdo_out;
        tck = 1'b1;
        #32;
        tck = 1'b0;
    endtask

    task automatic run(input logic m, input int n);
        logic o;
        repeat (n) tick(m, 1'b1, o);
    endtask

    // ----------------------------------------
    // idle to shift, n bits lsb first, back to idle
    // ----------------------------------------
    task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, o);
        if (ir)
            tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask
endmodule // scan_controller

//--- scan_test_port_tb.sv
// Purpose: self-checking bench of the boundary-scan test port
// Assumes: chain order io cells, input cells, macrocell cells
// Notes: small pin counts keep the chain short
`define CHK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            $display("unexpected %s expected %0h seen %0h", what, exp, got); \
            mismatches++; \
        end \
    end

module scan_test_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scan_port_pkg::*;

    localparam int NIO = 4;
    localparam int NIN = 2;
    localparam int NMC = 3;
    localparam int BSR = NIO * 3 + NIN + NMC;
    logic clk, sys_rst, scan_port_en, tck, tms, tdi;
    logic tdo_out, tdo_oe, tms_pullup_en, tdi_pullup_en, test_pins_user;
    logic [NIO-1:0] io_pin_in, core_out, core_oe, io_pin_out, io_pin_oe;
    logic [NIN-1:0] in_pin_in;
    logic [NMC-1:0] mc_state;
    logic [63:0] d;
    int mismatches, tests_run;
    int oe_cnt = 0;

    always #2.5 clk = ~clk;

    // counts rising test clock edges at which the device drives tdo
    always @(posedge tck)
        if (tdo_oe === 1'b1)
            oe_cnt++;

    scan_test_port #(.PULLUP_EN(1'b1), .N_IO(NIO), .N_IN(NIN), .N_MC(NMC)) dut (
        .clk(clk), .sys_rst(sys_rst), .scan_port_en(scan_port_en),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
        .tms_pullup_en(tms_pullup_en), .tdi_pullup_en(tdi_pullup_en),
        .test_pins_user(test_pins_user), .io_pin_in(io_pin_in), .in_pin_in(in_pin_in),
        .core_out(core_out), .core_oe(core_oe), .mc_state(mc_state),
        .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe)
    );

    scan_controller ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out));

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // tms held low through reset, so only the power-up reset selects idcode
    task automatic t_power_up();
        ctl.run(1'b0, 4);
        ctl.scan(1'b0, 64'h0, ID_LEN, d);
        `CHK("idcode", ID_VALUE, d[31:0])
        `CHK("tdo enable count", ID_LEN, oe_cnt)
        `CHK("tdo enable idle", 1'b0, tdo_oe)
        `CHK("tms pull-up", 1'b1, tms_pullup_en)
        `CHK("tdi pull-up", 1'b1, tdi_pullup_en)
        `CHK("pins user", 1'b0, test_pins_user)
    endtask

    task automatic t_bypass();
        logic [IR_LEN-1:0] codes [3];
        codes = '{INS_BYPASS, 4'h7, INS_HIGHZ};
        foreach (codes[i])
        begin
            ctl.scan(1'b1, 64'(codes[i]), IR_LEN, d);
            `CHK("ir capture", 4'h1, d[3:0])
            ctl.scan(1'b0, 64'hB5, 8, d);
            `CHK("bypass capture", 1'b0, d[0])
            `CHK("bypass path", 7'h35, d[7:1])
        end
        wait_clk(8);
        `CHK("highz enables", {NIO{1'b0}}, io_pin_oe)
    endtask

    task automatic t_sample_extest();
        logic [63:0] pre, exp;
        pre = '0;
        exp = '0;
        for (int i = 0; i < NIO; i++)
        begin
            exp[BSR-1-3*i] = io_pin_in[i];
            exp[BSR-2-3*i] = core_out[i];
            exp[BSR-3-3*i] = core_oe[i];
            pre[BSR-2-3*i] = ~core_out[i];
            pre[BSR-3-3*i] = ~core_oe[i];
        end
        for (int j = 0; j < NIN; j++)
            exp[BSR-1-3*NIO-j] = in_pin_in[j];
        for (int k = 0; k < NMC; k++)
            exp[NMC-1-k] = mc_state[k];
        ctl.scan(1'b1, 64'(INS_SAMPLE), IR_LEN, d);
        wait_clk(8);
        `CHK("pins follow core", 4'h6, io_pin_out)
        `CHK("enables follow core", 4'hC, io_pin_oe)
        ctl.scan(1'b0, pre, BSR, d);
        `CHK("boundary capture", exp[BSR-1:0], d[BSR-1:0])
        ctl.scan(1'b1, 64'(INS_EXTEST), IR_LEN, d);
        wait_clk(8);
        `CHK("extest pins", 4'h9, io_pin_out)
        `CHK("extest enables", 4'h3, io_pin_oe)
        @(posedge clk);
        core_out <= 4'h0;
        wait_clk(8);
        `CHK("extest pins held", 4'h9, io_pin_out)
    endtask

    // five tms highs leave bypass and extest behind without a reset pin
    task automatic t_tms_reset();
        ctl.run(1'b1, 5);
        ctl.run(1'b0, 1);
        wait_clk(8);
        `CHK("pins back to core", 4'h0, io_pin_out)
        ctl.scan(1'b1, 64'(INS_BYPASS), IR_LEN, d);
        ctl.run(1'b1, 5);
        ctl.run(1'b0, 1);
        ctl.scan(1'b0, 64'h0, ID_LEN, d);
        `CHK("idcode after tms reset", ID_VALUE, d[31:0])
    endtask

    task automatic t_disable();
        ctl.scan(1'b1, 64'(INS_BYPASS), IR_LEN, d);
        @(posedge clk);
        scan_port_en <= 1'b0;
        ctl.run(1'b1, 4);
        `CHK("pins user", 1'b1, test_pins_user)
        `CHK("tdo released", 1'b0, tdo_oe)
        @(posedge clk);
        scan_port_en <= 1'b1;
        ctl.run(1'b0, 4);
        wait_clk(4);
        `CHK("pins test", 1'b0, test_pins_user)
        ctl.scan(1'b0, 64'h0, ID_LEN, d);
        `CHK("idcode after enable", ID_VALUE, d[31:0])
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        scan_port_en = 1'b1;
        io_pin_in = 4'hA;
        in_pin_in = 2'h1;
        core_out = 4'h6;
        core_oe = 4'hC;
        mc_state = 3'h5;
        mismatches = 0;
        tests_run = 0;
        // held until the test clock has sampled it on several edges
        fork
            wait_clk(64);
            ctl.run(1'b0, 6);
        join
        @(posedge clk);
        sys_rst <= 1'b0;
        t_power_up();
        t_bypass();
        t_sample_extest();
        t_tms_reset();
        t_disable();
        stop_test();
    end

    initial
    begin
        #200us;
        mismatches++;
        stop_test();
    end
endmodule // scan_test_port_tb
